// file: src/usb_dma_teardown_rx.sv
// Transmit teardown control, completion pointers and receive descriptor write-back.
// Assumes the transmit engine acknowledges stop requests and a memory port accepts single-word writes.
// How it works
// - Transparent packets are limited by the endpoint's maximum packet size, not 64 bytes.
// - Teardown stops the channel's transfer and clears its queue state.
// - The teardown register shows a ready bit while a teardown may be started.
// - Writing a channel number to the teardown register starts that teardown.
// - Finished teardown raises the channel interrupt and loads the all-reclaim completion pointer.
// - Receive buffers are byte aligned and 1 to 65535 bytes long.
// - Receive descriptors are 16 bytes and 16-byte aligned.
// - A zero next-descriptor pointer marks the last buffer of the queue.
// - Ownership and length only on start descriptors; end-of-queue only on end descriptors.
// - Word 1 is the buffer start address used by the DMA.
// - Leading offset bytes are skipped; data begins right after them.
// - On start descriptors the shared buffer offset register replaces the zero offset.
// - Word 2 low half counts valid bytes, excluding leading skipped bytes.
// - End descriptors get the real byte count when fewer bytes arrived.
// - Start descriptors get a new length if offset nonzero or packet shorter.
// - Channel interrupt stays set until software writes back the matching pointer.
// - Ownership bit 29 is cleared by the DMA when the packet completes.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module usb_dma_teardown_rx
	import usb_dma_pkg::*;
#(
	parameter int NUM_CH = 4
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,

	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,

	// Transmit engine
	output logic [NUM_CH-1:0] tx_stop_req,
	input wire logic [NUM_CH-1:0] tx_stopped,
	input wire logic tx_done_valid,
	input wire logic [TD_CHAN_W-1:0] tx_done_ch,
	input wire logic [31:0] tx_done_addr,
	input wire logic [15:0] tx_pkt_len,
	output logic tx_len_err,
	output logic segmenting_dma_mode,
	output logic [NUM_CH-1:0] tx_chan_irq,

	// Receive descriptor completion
	input wire logic rx_desc_valid,
	output logic rx_desc_ready,
	input wire logic [31:0] rx_desc_addr,
	input wire logic [31:0] rx_next_ptr,
	input wire logic [31:0] rx_buf_ptr,
	input wire logic [15:0] rx_prog_len,
	input wire logic [15:0] rx_count,
	input wire logic [15:0] rx_pkt_len,
	input wire logic rx_sop,
	input wire logic rx_eop,
	output logic [31:0] rx_data_addr,
	output logic rx_last_buf,
	output logic rx_desc_err,

	// Memory write port
	output logic mem_wr_valid,
	input wire logic mem_wr_ready,
	output logic [31:0] mem_wr_addr,
	output logic [31:0] mem_wr_data
);
	// APB decode
	// Every access completes with zero wait states, so a write lands at the
	// edge that closes its access phase and nothing needs to stall the bus.
	// Unmapped offsets answer with an error and leave all state untouched.
	wire apb_wr = psel && penable && pwrite;
	wire apb_rd_sel = psel && !pwrite;
	wire [11:0] comp_idx = (paddr - OFS_COMP_BASE) >> 2;
	wire [11:0] head_idx = (paddr - OFS_HEAD_BASE) >> 2;
	wire hit_ctrl = paddr == OFS_GLOBAL_CTRL;
	wire hit_td = paddr == OFS_TX_TEARDOWN;
	wire hit_stat = paddr == OFS_TX_IRQ_STAT;
	wire hit_max = paddr == OFS_MAX_PKT;
	wire hit_rxofs = paddr == OFS_RX_BUF_OFS;
	wire hit_comp = paddr >= OFS_COMP_BASE && comp_idx < 12'(NUM_CH) && paddr[1:0] == 2'b00;
	wire hit_head = paddr >= OFS_HEAD_BASE && head_idx < 12'(NUM_CH) && paddr[1:0] == 2'b00;
	wire hit_any = hit_ctrl || hit_td || hit_stat || hit_max || hit_rxofs || hit_comp || hit_head;

	// Register state
	logic [31:0] global_ctrl_ff;
	logic [15:0] max_pkt_ff;
	logic [15:0] rx_buf_ofs_ff;
	logic [31:0] comp_ptr_ff [NUM_CH];
	logic [31:0] head_ptr_ff [NUM_CH];
	logic [NUM_CH-1:0] irq_ff;
	td_state_t td_state_ff;
	logic [TD_CHAN_W-1:0] td_chan_ff;

	// Only one teardown runs at a time; out-of-range channels are dropped
	// rather than latched, so a bad write cannot wedge the sequencer.
	wire td_ready = td_state_ff == TD_IDLE;
	wire td_start = apb_wr && hit_td && td_ready && pwdata[TD_CHAN_W-1:0] < TD_CHAN_W'(NUM_CH);
	wire td_stopped = tx_stopped[td_chan_ff[$clog2(NUM_CH)-1:0]];
	wire td_finish = td_state_ff == TD_FINISH;

	assign pready = 1'b1;
	// Error flags only the access phase, as the setup cycle carries no answer
	assign pslverr = psel && penable && !hit_any;
	assign segmenting_dma_mode = global_ctrl_ff[SEG_MODE_BIT];
	// Segmenting mode may split larger packets, so the size check applies only in transparent mode
	assign tx_len_err = !segmenting_dma_mode && tx_pkt_len > max_pkt_ff;
	assign tx_chan_irq = irq_ff;

	// Read mux
	// Holes inside the map read as zero.
	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h00000000;
		if (hit_ctrl) begin
			rd_data = global_ctrl_ff;
		end else if (hit_td) begin
			rd_data = {td_ready, {(32-1-TD_CHAN_W){1'b0}}, td_chan_ff};
		end else if (hit_stat) begin
			rd_data = 32'(irq_ff);
		end else if (hit_max) begin
			rd_data = {16'h0000, max_pkt_ff};
		end else if (hit_rxofs) begin
			rd_data = {16'h0000, rx_buf_ofs_ff};
		end else if (hit_comp) begin
			rd_data = comp_ptr_ff[comp_idx[$clog2(NUM_CH)-1:0]];
		end else if (hit_head) begin
			rd_data = head_ptr_ff[head_idx[$clog2(NUM_CH)-1:0]];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		// Captured in the setup cycle so read data comes from a flip-flop
		// and already stands during the whole access phase.
		end else if (apb_rd_sel && !penable) begin
			prdata <= rd_data;
		end
	end

	// Plain configuration registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			global_ctrl_ff <= GLOBAL_CTRL_RST;
			max_pkt_ff <= MAX_PKT_RST;
			rx_buf_ofs_ff <= RX_BUF_OFS_RST;
		end else if (apb_wr) begin
			// Only the mode bit is kept; the other control bits read as zero
			if (hit_ctrl) begin
				global_ctrl_ff <= {31'h00000000, pwdata[SEG_MODE_BIT]};
			end
			if (hit_max) begin
				max_pkt_ff <= pwdata[15:0];
			end
			if (hit_rxofs) begin
				rx_buf_ofs_ff <= pwdata[15:0];
			end
		end
	end

	// Teardown sequencer
	// Idle accepts a request, stop holds the stop request until the engine
	// confirms, finish clears the queue state and posts the interrupt.
	// The engine may take any time to confirm; there is no timeout here,
	// so a stuck engine keeps the ready bit low until reset.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			td_state_ff <= TD_IDLE;
			td_chan_ff <= '0;
		end else begin
			unique case (td_state_ff)
				TD_IDLE: begin
					if (td_start) begin
						td_chan_ff <= pwdata[TD_CHAN_W-1:0];
						td_state_ff <= TD_STOP;
					end
				end

				TD_STOP: begin
					if (td_stopped) begin
						td_state_ff <= TD_FINISH;
					end
				end

				TD_FINISH: begin
					td_state_ff <= TD_IDLE;
				end

				default: begin
					td_state_ff <= TD_IDLE;
				end
			endcase
		end
	end

	// Per-channel queue state, completion pointer and interrupt
	// Teardown outranks a packet completion in the same cycle, so the
	// all-reclaim pointer is not overwritten by a completion in the finish cycle.
	// A mismatched acknowledge leaves both pointer and interrupt as they are.
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			wire sel_td = td_chan_ff == TD_CHAN_W'(ch);
			wire td_end = td_finish && sel_td;
			wire done_hit = tx_done_valid && tx_done_ch == TD_CHAN_W'(ch);
			wire wr_comp = apb_wr && hit_comp && comp_idx == 12'(ch);
			wire wr_head = apb_wr && hit_head && head_idx == 12'(ch);

			assign tx_stop_req[ch] = td_state_ff == TD_STOP && sel_td;

			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					head_ptr_ff[ch] <= 32'h00000000;
				end else if (td_end) begin
					head_ptr_ff[ch] <= 32'h00000000;
				end else if (wr_head) begin
					head_ptr_ff[ch] <= pwdata;
				end
			end

			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					comp_ptr_ff[ch] <= 32'h00000000;
					irq_ff[ch] <= 1'b0;
				end else if (td_end) begin
					comp_ptr_ff[ch] <= TEARDOWN_DONE_PTR;
					irq_ff[ch] <= 1'b1;
				end else if (done_hit) begin
					// A completion in the same cycle as an acknowledge keeps the interrupt set
					comp_ptr_ff[ch] <= tx_done_addr;
					irq_ff[ch] <= 1'b1;
				end else if (wr_comp && pwdata == comp_ptr_ff[ch]) begin
					irq_ff[ch] <= 1'b0;
				end
			end
		end
	endgenerate

	// Receive descriptor write-back
	// Only words 2 and 3 are written back; words 0 and 1 belong to software.
	// The buffer offset register is shared by all channels, so software must
	// not change it while a start-of-packet descriptor is being completed.
	// A refused descriptor leaves memory untouched; it raises the error and still updates the data address and last-buffer outputs.
	wb_state_t wb_state_ff;
	logic [31:0] wb_addr_ff;
	logic [31:0] wb_word2_ff;
	logic [31:0] wb_word3_ff;
	logic [31:0] rx_data_addr_ff;
	logic rx_last_ff;
	logic rx_err_ff;

	wire desc_misaligned = (rx_desc_addr[3:0] & DESC_ALIGN_MASK) != 4'h0;
	wire len_bad = rx_prog_len == 16'h0000;
	// Descriptor fields are sampled only at the handshake edge
	wire take_desc = rx_desc_valid && rx_desc_ready;
	wire [15:0] sop_ofs = rx_sop ? rx_buf_ofs_ff : 16'h0000;
	wire sop_rewrite = rx_sop && (rx_buf_ofs_ff != 16'h0000 || rx_pkt_len < rx_prog_len);
	wire eop_rewrite = rx_eop && rx_count < rx_prog_len;
	wire [15:0] new_len = (sop_rewrite || eop_rewrite) ? rx_count : rx_prog_len;
	// Length and offset are rewritten together with the flags in one pass
	wire last_buf = rx_next_ptr == 32'h00000000;
	wire end_of_queue_flag = rx_eop && last_buf;
	wire [15:0] w3_len = rx_sop ? rx_pkt_len : 16'h0000;
	wire [31:0] new_word3 = {rx_sop, rx_eop, 1'b0, end_of_queue_flag, 12'h000, w3_len};

	wire [31:0] w2_addr = wb_addr_ff + DESC_W2_OFS;
	wire [31:0] w3_addr = wb_addr_ff + DESC_W3_OFS;

	// No new descriptor is taken until both words have left, so the
	// captured words never change under a stalled memory write.
	assign rx_desc_ready = wb_state_ff == WB_IDLE;
	assign mem_wr_valid = wb_state_ff != WB_IDLE;
	assign mem_wr_addr = wb_state_ff == WB_WORD3 ? w3_addr : w2_addr;
	assign mem_wr_data = wb_state_ff == WB_WORD3 ? wb_word3_ff : wb_word2_ff;
	assign rx_data_addr = rx_data_addr_ff;
	assign rx_last_buf = rx_last_ff;
	assign rx_desc_err = rx_err_ff;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wb_state_ff <= WB_IDLE;
			wb_addr_ff <= 32'h00000000;
			wb_word2_ff <= 32'h00000000;
			wb_word3_ff <= 32'h00000000;
			rx_data_addr_ff <= 32'h00000000;
			rx_last_ff <= 1'b0;
			rx_err_ff <= 1'b0;
		end else begin
			unique case (wb_state_ff)
				WB_IDLE: begin
					if (take_desc) begin
						rx_err_ff <= desc_misaligned || len_bad;
						rx_last_ff <= last_buf;
						rx_data_addr_ff <= rx_buf_ptr + 32'(sop_ofs);
						if (!desc_misaligned && !len_bad) begin
							wb_addr_ff <= rx_desc_addr;
							wb_word2_ff <= {sop_ofs, new_len};
							wb_word3_ff <= new_word3;
							wb_state_ff <= WB_WORD2;
						end
					end
				end

				// Each word stands until memory accepts it
				WB_WORD2: begin
					if (mem_wr_ready) begin
						wb_state_ff <= WB_WORD3;
					end
				end

				WB_WORD3: begin
					if (mem_wr_ready) begin
						wb_state_ff <= WB_IDLE;
					end
				end

				default: begin
					wb_state_ff <= WB_IDLE;
				end
			endcase
		end
	end
endmodule

// file: include/usb_dma_pkg.sv
// Package for the USB DMA teardown and receive-descriptor write-back block.
// Assumes a 32-bit APB register bus and 16-byte receive descriptors in memory.
package usb_dma_pkg;
	// Register byte offsets
	localparam logic [11:0] OFS_GLOBAL_CTRL = 12'h000;
	localparam logic [11:0] OFS_TX_TEARDOWN = 12'h004;
	localparam logic [11:0] OFS_TX_IRQ_STAT = 12'h008;
	localparam logic [11:0] OFS_MAX_PKT = 12'h00C;
	localparam logic [11:0] OFS_RX_BUF_OFS = 12'h010;
	localparam logic [11:0] OFS_COMP_BASE = 12'h040;
	localparam logic [11:0] OFS_HEAD_BASE = 12'h080;
	// Field positions
	localparam int SEG_MODE_BIT = 0;
	localparam int TD_READY_BIT = 31;
	localparam int TD_CHAN_W = 5;
	localparam int W3_SOP_BIT = 31;
	localparam int W3_EOP_BIT = 30;
	localparam int W3_OWN_BIT = 29;
	localparam int W3_EOQ_BIT = 28;
	// Reset and special values
	localparam logic [31:0] TEARDOWN_DONE_PTR = 32'hFFFFFFFC;
	localparam logic [15:0] MAX_PKT_RST = 16'h0040;
	localparam logic [15:0] RX_BUF_OFS_RST = 16'h0000;
	localparam logic [31:0] GLOBAL_CTRL_RST = 32'h00000000;
	// Descriptor geometry
	localparam logic [31:0] DESC_W2_OFS = 32'h00000008;
	localparam logic [31:0] DESC_W3_OFS = 32'h0000000C;
	localparam logic [3:0] DESC_ALIGN_MASK = 4'hF;
	typedef enum logic [1:0] {
		TD_IDLE = 2'b00,
		TD_STOP = 2'b01,
		TD_FINISH = 2'b10
	} td_state_t;
	typedef enum logic [1:0] {
		WB_IDLE = 2'b00,
		WB_WORD2 = 2'b01,
		WB_WORD3 = 2'b10
	} wb_state_t;
endpackage

// file: test/usb_dma_teardown_rx_checker.sv
// Port assertions for usb_dma_teardown_rx: teardown handshake and rx write-back.
// Bound to the design; the teardown checks other than a_one_teardown watch channel 1, the one the bench tears down.
`timescale 1ns/1ps
module usb_dma_teardown_rx_checker
	import usb_dma_pkg::*;
#(parameter int NUM_CH = 4) (
	input wire logic mclk, rst_n, psel, penable, pwrite,
	input wire logic [11:0] paddr,
	input wire logic [NUM_CH-1:0] tx_stop_req, tx_stopped, tx_chan_irq,
	input wire logic rx_desc_valid, rx_desc_ready, rx_last_buf, mem_wr_valid, mem_wr_ready,
	input wire logic [31:0] rx_desc_addr, rx_next_ptr, mem_wr_addr, mem_wr_data,
	input wire logic [15:0] rx_prog_len
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire good = rx_desc_valid && rx_desc_ready && rx_desc_addr[3:0] == 4'h0 && rx_prog_len != 16'h0;
	wire w3 = mem_wr_valid && mem_wr_addr[3:0] == 4'hC;
	wire clr1 = psel && penable && pwrite && paddr == OFS_COMP_BASE + 12'h4;
	a_one_teardown: assert property ($onehot0(tx_stop_req)) else $error("two teardowns at once");
	a_stop_held: assert property (tx_stop_req[1] && !tx_stopped[1] |=> tx_stop_req[1])
		else $error("stop request dropped");
	a_td_irq: assert property (tx_stop_req[1] && tx_stopped[1] |=> !tx_stop_req[1] ##1 tx_chan_irq[1])
		else $error("teardown irq late");
	a_irq_holds: assert property (tx_chan_irq[1] && !clr1 |=> tx_chan_irq[1]) else $error("irq lost");
	a_wb_word2: assert property (good |=> mem_wr_valid && mem_wr_addr == $past(rx_desc_addr) + DESC_W2_OFS)
		else $error("word2 write missing");
	a_last_buf: assert property (good |=> rx_last_buf == ($past(rx_next_ptr) == 32'h0))
		else $error("last buffer wrong");
	a_own_clear: assert property (w3 |-> !mem_wr_data[W3_OWN_BIT]) else $error("ownership set");
	a_eoq_eop: assert property (w3 && !mem_wr_data[W3_EOP_BIT] |-> !mem_wr_data[W3_EOQ_BIT])
		else $error("eoq without eop");
	a_w3_order: assert property (mem_wr_valid && mem_wr_ready && mem_wr_addr[3:0] == 4'h8 |=> w3)
		else $error("word3 not next");
	cover property (good);
	cover property (tx_stop_req[1] && tx_stopped[1]);
	cover property (tx_chan_irq[1] && clr1);
endmodule
bind usb_dma_teardown_rx usb_dma_teardown_rx_checker #(.NUM_CH(NUM_CH)) chk_i (.mclk, .rst_n, .psel, .penable,
	.pwrite, .paddr, .tx_stop_req, .tx_stopped, .tx_chan_irq, .rx_desc_valid, .rx_desc_ready, .rx_last_buf,
	.mem_wr_valid, .mem_wr_ready, .rx_desc_addr, .rx_next_ptr, .mem_wr_addr, .mem_wr_data, .rx_prog_len);

// file: test/usb_dma_partner.sv
// Far side: a transmit engine that confirms stops, and descriptor memory.
// Memory may stall every other cycle, so write-back must hold its request.
`timescale 1ns/1ps
module usb_dma_partner #(parameter int NUM_CH = 4) (
	input wire logic mclk, rst_n, slow,
	input wire logic [NUM_CH-1:0] tx_stop_req,
	output logic [NUM_CH-1:0] tx_stopped,
	input wire logic mem_wr_valid,
	output logic mem_wr_ready,
	input wire logic [31:0] mem_wr_addr, mem_wr_data,
	output logic [31:0] w2_ff, w3_ff
);
	logic [2:0] cnt_ff;
	logic tog_ff;
	wire acc = mem_wr_valid && mem_wr_ready;
	assign mem_wr_ready = !slow || tog_ff;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 3'h0;
			tog_ff <= 1'b0;
			tx_stopped <= '0;
			w2_ff <= '0;
			w3_ff <= '0;
		end else begin
			tog_ff <= !tog_ff;
			cnt_ff <= |tx_stop_req ? cnt_ff + 3'h1 : 3'h0;
			// A busy engine confirms the stop late, keeping the request up meanwhile
			tx_stopped <= cnt_ff == 3'h7 ? tx_stop_req : '0;
			if (acc && mem_wr_addr[3:0] == 4'h8) w2_ff <= mem_wr_data;
			if (acc && mem_wr_addr[3:0] == 4'hC) w3_ff <= mem_wr_data;
		end
	end
endmodule

// file: test/usb_dma_teardown_rx_tb_top.sv
// Self-checking bench: registers, teardown handshake, receive write-back.
// Uses usb_dma_partner as engine and memory; software acts through the APB tasks.
`timescale 1ns/1ps
module usb_dma_teardown_rx_tb_top
	import usb_dma_pkg::*;
;
	logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, se;
	logic pready, pslverr, tx_done_valid = 0, tx_len_err, segmenting_dma_mode, rx_desc_valid = 0;
	logic rx_sop = 0, rx_eop = 0, rx_desc_ready, rx_last_buf, rx_desc_err, mem_wr_valid, mem_wr_ready;
	logic [11:0] paddr = '0;
	logic [4:0] tx_done_ch = '0;
	logic [3:0] tx_stop_req, tx_stopped, tx_chan_irq;
	logic [31:0] pwdata = '0, prdata, rd, tx_done_addr = '0, rx_desc_addr = '0, rx_next_ptr = '0;
	logic [31:0] rx_buf_ptr = 32'h2000, rx_data_addr, mem_wr_addr, mem_wr_data, w2_ff, w3_ff;
	logic [15:0] tx_pkt_len = '0, rx_prog_len = '0, rx_count = '0, rx_pkt_len = '0;
	int errors = 0, n_checks = 0, cyc = 0;
	always #12.5 mclk = ~mclk;
	usb_dma_teardown_rx #(.NUM_CH(4)) DUT (.*);
	usb_dma_partner #(.NUM_CH(4)) far_i (.*);
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic r;
		@(posedge mclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do begin
			@(posedge mclk);
			r = pready;
			rd = prdata;
			se = pslverr;
		end while (r !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic t_regs();
		apb(0, OFS_MAX_PKT, 0);
		chk("max_pkt", rd, {16'h0, MAX_PKT_RST});
		apb(0, OFS_TX_TEARDOWN, 0);
		chk("ready", rd, 32'h80000000);
		apb(1, 12'hFFC, 32'h1);
		apb(0, 12'hFFC, 0);
		chk("unmapped", {rd[30:0], se}, 32'h1);
		apb(1, OFS_MAX_PKT, 32'h23);
		apb(1, OFS_GLOBAL_CTRL, 0);
		for (int i = 0; i < 3; i++) begin
			tx_pkt_len <= 16'h0022 + 16'(i);
			@(posedge mclk);
			#1;
			chk("len_err", tx_len_err, i == 2);
			@(posedge mclk);
		end
		apb(1, OFS_GLOBAL_CTRL, 1);
		#1;
		chk("seg", {segmenting_dma_mode, tx_len_err}, 2'b10);
		apb(1, OFS_GLOBAL_CTRL, 0);
		$display("test regs done");
	endtask
	task automatic t_teardown();
		apb(1, OFS_HEAD_BASE + 12'h4, 32'h1230);
		apb(1, OFS_TX_TEARDOWN, 32'h1);
		apb(1, OFS_TX_TEARDOWN, 32'h2);
		apb(0, OFS_TX_TEARDOWN, 0);
		chk("busy", {rd[31], tx_stop_req}, 5'h02);
		// Software waits for the teardown before any flush or restart
		for (int i = 0; i < 40 && tx_chan_irq[1] !== 1'b1; i++) @(posedge mclk);
		#1;
		chk("irq", tx_chan_irq, 4'h2);
		apb(0, OFS_COMP_BASE + 12'h4, 0);
		chk("comp", rd, TEARDOWN_DONE_PTR);
		apb(0, OFS_HEAD_BASE + 12'h4, 0);
		chk("head", rd, 0);
		apb(0, OFS_TX_TEARDOWN, 0);
		chk("idle", {rd[31], tx_stop_req}, 5'h10);
		apb(1, OFS_COMP_BASE + 12'h4, 32'h1230);
		#1;
		chk("irq_kept", tx_chan_irq[1], 1);
		apb(1, OFS_COMP_BASE + 12'h4, TEARDOWN_DONE_PTR);
		#1;
		chk("irq_clr", tx_chan_irq[1], 0);
		@(posedge mclk);
		tx_done_valid <= 1;
		tx_done_addr <= 32'h500;
		@(posedge mclk);
		tx_done_valid <= 0;
		apb(0, OFS_COMP_BASE, 0);
		chk("done", {rd[30:0], tx_chan_irq[0]}, 32'hA01);
		$display("test teardown done");
	endtask
	task automatic rx_one(input logic sl, input logic [3:0] a, input logic s, e, input logic [15:0] cn, pl,
		input logic [31:0] nx, ew2, ew3);
		logic r;
		@(posedge mclk);
		slow <= sl;
		rx_desc_addr <= {28'h0000100, a};
		rx_next_ptr <= nx;
		rx_prog_len <= 16'd100;
		rx_count <= cn;
		rx_pkt_len <= pl;
		rx_sop <= s;
		rx_eop <= e;
		rx_desc_valid <= 1;
		do begin
			@(posedge mclk);
			r = rx_desc_ready;
		end while (r !== 1'b1);
		rx_desc_valid <= 0;
		#1;
		for (int i = 0; i < 20 && rx_desc_ready !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		chk("word2", w2_ff, ew2);
		chk("word3", w3_ff, ew3);
		chk("err", rx_desc_err, a != 0);
		if (a == 0) begin
			chk("data", rx_data_addr, 32'h2000 + (s ? 32'h5 : 32'h0));
			chk("last", rx_last_buf, nx == 0);
		end
	endtask
	task automatic t_rx();
		apb(1, OFS_RX_BUF_OFS, 32'h5);
		rx_one(0, 0, 1, 1, 16'd10, 16'd10, 0, 32'h0005000A, 32'hD000000A);
		rx_one(1, 0, 0, 1, 16'd20, 16'd99, 32'h40, 32'h00000014, 32'h40000000);
		rx_one(1, 0, 0, 0, 16'd20, 16'd99, 32'h40, 32'h00000064, 32'h00000000);
		rx_one(1, 0, 0, 1, 16'd100, 16'd99, 0, 32'h00000064, 32'h50000000);
		rx_one(0, 4, 1, 1, 16'd10, 16'd10, 0, 32'h00000064, 32'h50000000);
		$display("test rx done");
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1;
		t_regs();
		t_teardown();
		t_rx();
		final_report();
	end
endmodule
